//--- hw/alarm_tone.sv
module alarm_tone #(
  parameter logic [31:0] SLOT_CYCLES = enclosure_alarm_pkg::SLOT_CYC
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic                      enable,
  input  enclosure_alarm_pkg::err_t      sev,
  output logic                           horn
);

  typedef struct packed {
    logic [31:0] cnt;
    logic [2:0]  slot;
    logic        horn;
  } tone_state_t;

  tone_state_t s_ff;
  tone_state_t nxt_s;
  logic [1:0]  beeps;

  always_comb begin
    beeps = enclosure_alarm_pkg::sev_beeps(sev);
    nxt_s = s_ff;
    if (!enable) begin
      nxt_s = '0;
    end else begin
      if (s_ff.cnt >= SLOT_CYCLES - 32'h1) begin
        nxt_s.cnt = '0;
        nxt_s.slot = s_ff.slot + 3'h1;
      end else begin
        nxt_s.cnt = s_ff.cnt + 32'h1;
      end
      // Even slots sound, up to the beep count; every slot sounds for unrecoverable
      nxt_s.horn = sev.unrec || (!s_ff.slot[0] && s_ff.slot[2:1] < beeps);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign horn = s_ff.horn;

  a_unrec_steady: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    enable && sev.unrec |=> horn
  ) else $error("unrecoverable tone not continuous");

  a_info_once: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    enable && sev == 4'h1 && s_ff.slot[2:1] != 2'h0 |=> !horn
  ) else $error("information tone sounded more than once");

endmodule : alarm_tone

//--- hw/btn_classify.sv
module btn_classify #(
  parameter logic [31:0] DEB_CYCLES  = enclosure_alarm_pkg::DEB_CYC,
  parameter logic [31:0] HOLD_CYCLES = enclosure_alarm_pkg::HOLD_CYC,
  parameter logic [31:0] REP_CYCLES  = enclosure_alarm_pkg::REP_CYC
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rst_n,
  input  wire logic                          btn_n,
  output enclosure_alarm_pkg::btn_evt_t      evt
);

  typedef struct packed {
    logic [2:0]                     sync;
    logic                           down;
    logic                           held;
    logic [31:0]                    debCnt;
    logic [31:0]                    holdCnt;
    enclosure_alarm_pkg::btn_evt_t  evt;
  } btn_state_t;

  btn_state_t s_ff;
  btn_state_t nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.evt = '0;
    nxt_s.sync = {s_ff.sync[1:0], ~btn_n};
    // Debounce on agreeing second and third stages
    if (s_ff.sync[2] == s_ff.sync[1] && s_ff.sync[2] != s_ff.down) begin
      if (s_ff.debCnt >= DEB_CYCLES - 32'h1) begin
        nxt_s.debCnt = '0;
        nxt_s.down = s_ff.sync[2];
        nxt_s.holdCnt = '0;
        if (s_ff.sync[2]) begin
          nxt_s.evt.press = 1'b1;
          nxt_s.held = 1'b0;
        end else if (!s_ff.held) begin
          nxt_s.evt.tap = 1'b1;
        end
      end else begin
        nxt_s.debCnt = s_ff.debCnt + 32'h1;
      end
    end else begin
      nxt_s.debCnt = '0;
    end
    // Hold threshold, then repeat ticks
    if (s_ff.down && nxt_s.down) begin
      nxt_s.holdCnt = s_ff.holdCnt + 32'h1;
      if (!s_ff.held && s_ff.holdCnt >= HOLD_CYCLES - 32'h1) begin
        nxt_s.held = 1'b1;
        nxt_s.evt.hold = 1'b1;
        nxt_s.holdCnt = '0;
      end else if (s_ff.held && s_ff.holdCnt >= REP_CYCLES - 32'h1) begin
        nxt_s.evt.repeat_ = 1'b1;
        nxt_s.holdCnt = '0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign evt = s_ff.evt;

  a_tap_no_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_ff.evt.tap |-> !s_ff.held && !s_ff.down
  ) else $error("tap reported after a hold");

endmodule : btn_classify

//--- hw/enclosure_alarm_panel.sv
module enclosure_alarm_panel #(
  parameter logic [31:0] DEB_CYCLES    = enclosure_alarm_pkg::DEB_CYC,
  parameter logic [31:0] HOLD_CYCLES   = enclosure_alarm_pkg::HOLD_CYC,
  parameter logic [31:0] REP_CYCLES    = enclosure_alarm_pkg::REP_CYC,
  parameter logic [31:0] SLOT_CYCLES   = enclosure_alarm_pkg::SLOT_CYC,
  parameter logic [31:0] REVERT_CYCLES = enclosure_alarm_pkg::REVERT_CYC
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic                        upperBtn_n,
  input  wire logic                        lowerBtn_n,
  input  enclosure_alarm_pkg::err_t        errActive,
  input  wire logic                        newError,
  input  wire logic                        reportViewed,
  input  wire logic                        addrAttached,
  input  wire logic [4:0]                  addrPos,
  output enclosure_alarm_pkg::panel_out_t  panel
);

  typedef struct packed {
    enclosure_alarm_pkg::panel_st_t  st;
    enclosure_alarm_pkg::group_t     group;
    logic                            alarmEn;
    logic                            muted;
    logic                            editVal;
    logic [3:0]                      pending;
    logic [31:0]                     revert;
    logic [5:0]                      addrS1;
    logic [5:0]                      addrS2;
    logic [5:0]                      addrS3;
    logic                            attached;
    logic [4:0]                      number;
    logic                            upperLed;
    logic                            lowerLed;
    logic                            hornEn;
    logic                            fwd;
    enclosure_alarm_pkg::err_t       sev;
  } ctl_t;

  ctl_t                           s_ff;
  ctl_t                           nxt_s;
  enclosure_alarm_pkg::btn_evt_t  up;
  enclosure_alarm_pkg::btn_evt_t  lo;
  logic                           hornOut;
  logic                           anyErr;
  logic                           anyPress;
  logic                           timeout;

  btn_classify #(
    .DEB_CYCLES  (DEB_CYCLES),
    .HOLD_CYCLES (HOLD_CYCLES),
    .REP_CYCLES  (REP_CYCLES)
  ) u_upper (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .btn_n   (upperBtn_n),
    .evt     (up)
  );

  btn_classify #(
    .DEB_CYCLES  (DEB_CYCLES),
    .HOLD_CYCLES (HOLD_CYCLES),
    .REP_CYCLES  (REP_CYCLES)
  ) u_lower (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .btn_n   (lowerBtn_n),
    .evt     (lo)
  );

  alarm_tone #(
    .SLOT_CYCLES (SLOT_CYCLES)
  ) u_tone (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .enable  (s_ff.hornEn),
    .sev     (s_ff.sev),
    .horn    (hornOut)
  );

  always_comb begin
    anyErr = |errActive;
    anyPress = up.press | lo.press;
    timeout = (s_ff.revert >= REVERT_CYCLES - 32'h1) && !anyPress;
    nxt_s = s_ff;

    // Address bus pins, three stage capture
    nxt_s.addrS1 = {addrAttached, addrPos};
    nxt_s.addrS2 = s_ff.addrS1;
    nxt_s.addrS3 = s_ff.addrS2;
    if (s_ff.addrS2 == s_ff.addrS3) begin
      nxt_s.attached = s_ff.addrS3[5];
      if (s_ff.addrS3[5]) begin
        nxt_s.number = s_ff.addrS3[4:0];
      end else begin
        nxt_s.number = enclosure_alarm_pkg::NUM_DETACHED;
      end
    end

    // Idle timer restarts on every press
    if (anyPress) begin
      nxt_s.revert = '0;
    end else if (!timeout) begin
      nxt_s.revert = s_ff.revert + 32'h1;
    end

    case (s_ff.st)
      enclosure_alarm_pkg::ST_NUMBER: begin
        if (lo.tap) begin
          nxt_s.st = enclosure_alarm_pkg::ST_GROUP;
          nxt_s.group = enclosure_alarm_pkg::GV_ENCLOSURE;
        end
      end
      enclosure_alarm_pkg::ST_GROUP: begin
        if (lo.tap) begin
          nxt_s.group = enclosure_alarm_pkg::next_group(s_ff.group);
        end else if (up.tap && s_ff.group == enclosure_alarm_pkg::GV_ENCLOSURE) begin
          nxt_s.st = enclosure_alarm_pkg::ST_NUMBER;
        end else if (up.hold && s_ff.group == enclosure_alarm_pkg::GV_ALARM_SETTING) begin
          nxt_s.st = enclosure_alarm_pkg::ST_EDIT;
          nxt_s.editVal = s_ff.alarmEn;
        end
      end
      enclosure_alarm_pkg::ST_EDIT: begin
        if (up.repeat_) begin
          nxt_s.editVal = !s_ff.editVal;
        end else if (up.tap) begin
          nxt_s.editVal = !s_ff.editVal;
        end
        if (lo.tap) begin
          nxt_s.alarmEn = s_ff.editVal;
          nxt_s.st = enclosure_alarm_pkg::ST_GROUP;
          nxt_s.group = enclosure_alarm_pkg::GV_ALARM_SETTING;
        end
      end
      default: begin
        nxt_s.st = enclosure_alarm_pkg::ST_NUMBER;
      end
    endcase

    // Mute toggles on each lower-button hold outside edit
    if (lo.hold && s_ff.st != enclosure_alarm_pkg::ST_EDIT) begin
      nxt_s.muted = !s_ff.muted;
    end

    // Back to enclosure number when idle with no error active
    if (timeout && !anyErr && s_ff.st != enclosure_alarm_pkg::ST_NUMBER) begin
      nxt_s.st = enclosure_alarm_pkg::ST_NUMBER;
    end

    // A new error clears mute and takes the display
    if (newError) begin
      nxt_s.muted = 1'b0;
      nxt_s.alarmEn = s_ff.alarmEn;
      nxt_s.st = enclosure_alarm_pkg::ST_GROUP;
      nxt_s.group = enclosure_alarm_pkg::GV_FAULT;
    end

    // Unviewed report count, held when arrival and view coincide
    case ({newError, reportViewed})
      2'h2: begin
        if (s_ff.pending != enclosure_alarm_pkg::PEND_MAX) begin
          nxt_s.pending = s_ff.pending + 4'h1;
        end
      end
      2'h1: begin
        if (s_ff.pending != 4'h0) begin
          nxt_s.pending = s_ff.pending - 4'h1;
        end
      end
      default: begin
        nxt_s.pending = s_ff.pending;
      end
    endcase

    nxt_s.upperLed = nxt_s.pending != 4'h0;
    nxt_s.lowerLed = nxt_s.muted || !nxt_s.alarmEn;
    nxt_s.hornEn = anyErr && nxt_s.alarmEn && !nxt_s.muted;
    nxt_s.fwd = anyErr;
    nxt_s.sev = errActive;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
      s_ff.st <= enclosure_alarm_pkg::ST_NUMBER;
      s_ff.group <= enclosure_alarm_pkg::GV_ENCLOSURE;
      s_ff.alarmEn <= enclosure_alarm_pkg::RST_ALARM_EN;
    end else begin
      s_ff <= nxt_s;
    end
  end

  always_comb begin
    panel = '0;
    panel.upperLed = s_ff.upperLed;
    panel.lowerLed = s_ff.lowerLed;
    panel.horn = hornOut;
    panel.commEnable = s_ff.attached;
    panel.faultForward = s_ff.fwd;
    panel.number = s_ff.number;
    panel.group = s_ff.group;
    panel.showNumber = s_ff.st == enclosure_alarm_pkg::ST_NUMBER;
    panel.showSetting = s_ff.st == enclosure_alarm_pkg::ST_EDIT;
    panel.settingOn = s_ff.editVal;
    panel.flash = s_ff.st == enclosure_alarm_pkg::ST_EDIT
               || (s_ff.st == enclosure_alarm_pkg::ST_GROUP
                   && s_ff.group == enclosure_alarm_pkg::GV_FAULT && s_ff.fwd);
  end

  a_led_arrival: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    newError && !reportViewed |=> panel.upperLed
  ) else $error("upper LED dark after new error");

  a_led_last_view: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_ff.pending == 4'h2 && reportViewed && !newError
      ##1 !newError && !reportViewed |=> panel.upperLed
  ) else $error("upper LED dark before last report viewed");

  a_led_cleared: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_ff.pending == 4'h1 && reportViewed && !newError |=> !panel.upperLed
  ) else $error("upper LED lit after last report viewed");

  a_lower_commit: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_ff.st == enclosure_alarm_pkg::ST_EDIT && lo.tap && !newError
      |=> panel.lowerLed == (s_ff.muted || !$past(s_ff.editVal))
        && s_ff.group == enclosure_alarm_pkg::GV_ALARM_SETTING && !panel.flash
  ) else $error("commit did not update lower LED or display");

  a_disabled_quiet: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !s_ff.alarmEn ##1 !s_ff.alarmEn |-> !panel.horn
  ) else $error("horn sounded while disabled");

  a_new_unmutes: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    newError && s_ff.alarmEn |=> !s_ff.muted && !panel.lowerLed
  ) else $error("new error left alarm muted");

  a_mute_toggle: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    lo.hold && s_ff.st != enclosure_alarm_pkg::ST_EDIT && !newError
      |=> s_ff.muted != $past(s_ff.muted)
  ) else $error("hold did not toggle mute");

  a_group_step: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    lo.tap && s_ff.st == enclosure_alarm_pkg::ST_GROUP && !newError && !timeout
      |=> s_ff.group == enclosure_alarm_pkg::next_group($past(s_ff.group))
  ) else $error("group did not step");

  a_edit_enter: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    up.hold && s_ff.st == enclosure_alarm_pkg::ST_GROUP && !lo.tap && !newError
      && s_ff.group == enclosure_alarm_pkg::GV_ALARM_SETTING && !timeout
      |=> panel.flash && panel.showSetting && panel.settingOn == s_ff.alarmEn
  ) else $error("hold on alarm group did not enter edit");

  a_detached_zero: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !addrAttached [*4] |=> panel.number == 5'h00 && !panel.commEnable
  ) else $error("detached unit not showing zero");

  a_fault_kept: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    newError |=> s_ff.group == enclosure_alarm_pkg::GV_FAULT
      && s_ff.st == enclosure_alarm_pkg::ST_GROUP
  ) else $error("fault group not shown on new error");

  a_idle_revert: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    timeout && !anyErr && !newError |=> panel.showNumber
  ) else $error("display did not return to enclosure number");

  a_lower_led_level: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    panel.lowerLed == (s_ff.muted || !s_ff.alarmEn)
  ) else $error("lower LED does not follow mute and setting");

  a_upper_led_level: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    panel.upperLed == (s_ff.pending != 4'h0)
  ) else $error("upper LED does not follow unviewed reports");

  a_pending_sat: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_ff.pending == enclosure_alarm_pkg::PEND_MAX && newError && !reportViewed
      |=> s_ff.pending == enclosure_alarm_pkg::PEND_MAX
  ) else $error("unviewed report count wrapped");

  a_horn_gate: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    1'b1 |=> s_ff.hornEn == ($past(anyErr) && s_ff.alarmEn && !s_ff.muted)
  ) else $error("horn enable does not follow errors, mute and setting");

  a_horn_silent: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !s_ff.hornEn |=> !panel.horn
  ) else $error("horn sounded without enable");

  a_fwd_level: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    1'b1 |=> panel.faultForward == $past(anyErr)
  ) else $error("fault forwarding does not follow errors");

  a_edit_no_mute: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    lo.hold && s_ff.st == enclosure_alarm_pkg::ST_EDIT && !newError
      |=> s_ff.muted == $past(s_ff.muted)
  ) else $error("lower hold changed mute in edit");

  a_edit_toggle: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_ff.st == enclosure_alarm_pkg::ST_EDIT && (up.repeat_ || up.tap) && !newError
      |=> panel.settingOn != $past(panel.settingOn)
  ) else $error("shown setting did not advance");

  a_flash_edit: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    panel.showSetting |-> panel.flash
  ) else $error("setting shown without flashing");

  a_number_tap: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_ff.st == enclosure_alarm_pkg::ST_NUMBER && lo.tap && !newError
      |=> !panel.showNumber && panel.group == enclosure_alarm_pkg::GV_ENCLOSURE
  ) else $error("tap from number did not show first group");

  a_detached_number: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !panel.commEnable |-> panel.number == enclosure_alarm_pkg::NUM_DETACHED
  ) else $error("detached unit shows a nonzero number");

  a_press_restarts: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    anyPress |=> s_ff.revert == 32'h0
  ) else $error("press did not restart idle timer");

  a_revert_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    anyErr && !panel.showNumber && !up.tap |=> !panel.showNumber
  ) else $error("display returned to number with errors present");

endmodule : enclosure_alarm_panel

//--- hw/enclosure_alarm_pkg.sv
package enclosure_alarm_pkg;

  localparam longint CLK_HZ    = 50_000_000;
  localparam longint DEB_MS    = 10;
  localparam longint HOLD_MS   = 2000;
  localparam longint REP_MS    = 250;
  localparam longint SLOT_MS   = 250;
  localparam longint REVERT_S  = 60;
  localparam logic [31:0] DEB_CYC    = 32'(CLK_HZ * DEB_MS / 1000);
  localparam logic [31:0] HOLD_CYC   = 32'(CLK_HZ * HOLD_MS / 1000);
  localparam logic [31:0] REP_CYC    = 32'(CLK_HZ * REP_MS / 1000);
  localparam logic [31:0] SLOT_CYC   = 32'(CLK_HZ * SLOT_MS / 1000);
  localparam logic [31:0] REVERT_CYC = 32'(CLK_HZ * REVERT_S);

  localparam int         PEND_W       = 4;
  localparam logic [3:0] PEND_MAX     = 4'hF;
  localparam logic       RST_ALARM_EN = 1'h1;
  localparam logic [4:0] NUM_DETACHED = 5'h00;

  typedef struct packed {
    logic unrec;
    logic crit;
    logic noncrit;
    logic info;
  } err_t;

  typedef struct packed {
    logic press;
    logic tap;
    logic hold;
    logic repeat_;
  } btn_evt_t;

  typedef enum logic [2:0] {
    ST_NUMBER = 3'h1,
    ST_GROUP  = 3'h2,
    ST_EDIT   = 3'h4
  } panel_st_t;

  typedef enum logic [2:0] {
    GV_ENCLOSURE     = 3'h0,
    GV_LOOP_ID       = 3'h1,
    GV_REPORT_GROUP  = 3'h2,
    GV_ALARM_SETTING = 3'h3,
    GV_FAULT         = 3'h4
  } group_t;

  typedef struct packed {
    logic       upperLed;
    logic       lowerLed;
    logic       flash;
    logic       horn;
    logic       commEnable;
    logic       faultForward;
    logic       showNumber;
    logic       showSetting;
    logic       settingOn;
    group_t     group;
    logic [4:0] number;
  } panel_out_t;

  function automatic logic [1:0] sev_beeps(input err_t e);
    if (e.crit) return 2'h3;
    if (e.noncrit) return 2'h2;
    if (e.info) return 2'h1;
    return 2'h0;
  endfunction : sev_beeps

  function automatic group_t next_group(input group_t g);
    case (g)
      GV_ENCLOSURE:     return GV_LOOP_ID;
      GV_LOOP_ID:       return GV_REPORT_GROUP;
      GV_REPORT_GROUP:  return GV_ALARM_SETTING;
      GV_ALARM_SETTING: return GV_FAULT;
      default:          return GV_ENCLOSURE;
    endcase
  endfunction : next_group

endpackage : enclosure_alarm_pkg

//--- test/enclosure_alarm_panel_tb.sv
`define CHECK(act, exp) \
  begin \
    numChecks++; \
    if ((act) !== (exp)) begin \
      errors++; \
      $display("unexpected at %0t: got %0h expected %0h", $time, (act), (exp)); \
    end \
  end

module enclosure_alarm_panel_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SLOTS = 4;

  logic                            ref_clk;
  logic                            rst_n;
  logic                            upperBtn_n;
  logic                            lowerBtn_n;
  enclosure_alarm_pkg::err_t       errActive;
  logic                            newError;
  logic                            reportViewed;
  logic                            addrAttached;
  logic [4:0]                      addrPos;
  enclosure_alarm_pkg::panel_out_t panel;
  int                              errors;
  int                              numChecks;
  int                              toggles;
  int                              h;
  logic                            seen;
  logic                            lastSet;
  logic [4:0]                      posList [3] = '{5'h01, 5'h0E, 5'h18};
  enclosure_alarm_pkg::group_t     grpSeq [6] = '{enclosure_alarm_pkg::GV_ENCLOSURE,
    enclosure_alarm_pkg::GV_LOOP_ID, enclosure_alarm_pkg::GV_REPORT_GROUP,
    enclosure_alarm_pkg::GV_ALARM_SETTING, enclosure_alarm_pkg::GV_FAULT,
    enclosure_alarm_pkg::GV_ENCLOSURE};
  logic [3:0]                      sevList [4] = '{4'h8, 4'h5, 4'h3, 4'h1};
  int                              beeps [4] = '{8, 3, 2, 1};

  enclosure_alarm_panel #(
    .DEB_CYCLES   (32'h4),
    .HOLD_CYCLES  (32'h14),
    .REP_CYCLES   (32'h10),
    .SLOT_CYCLES  (32'h4),
    .REVERT_CYCLES(32'h64)
  ) enclosure_alarm_panel_inst (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .upperBtn_n  (upperBtn_n),
    .lowerBtn_n  (lowerBtn_n),
    .errActive   (errActive),
    .newError    (newError),
    .reportViewed(reportViewed),
    .addrAttached(addrAttached),
    .addrPos     (addrPos),
    .panel       (panel)
  );

  panel_operator panel_operator_inst (
    .ref_clk   (ref_clk),
    .panel     (panel),
    .upperBtn_n(upperBtn_n),
    .lowerBtn_n(lowerBtn_n)
  );

  initial begin
    ref_clk = 1'h0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Counts changes of the shown setting
  always @(posedge ref_clk) begin
    if (panel.settingOn !== lastSet) begin
      toggles++;
      lastSet = panel.settingOn;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task automatic raise(input logic [3:0] sev);
    @(posedge ref_clk);
    errActive <= sev;
    newError  <= 1'h1;
    @(posedge ref_clk);
    newError  <= 1'h0;
  endtask : raise

  task automatic view();
    @(posedge ref_clk);
    reportViewed <= 1'h1;
    @(posedge ref_clk);
    reportViewed <= 1'h0;
  endtask : view

  // Horn high cycles over one whole alarm cycle of eight slots
  task automatic hornHighs(output int highs);
    highs = 0;
    repeat (8 * SLOTS) begin
      @(posedge ref_clk);
      if (panel.horn === 1'h1) highs++;
    end
  endtask : hornHighs

  task automatic goGroup(input enclosure_alarm_pkg::group_t g);
    for (int i = 0; i < 6; i++) begin
      if (panel.showNumber === 1'h0 && panel.showSetting === 1'h0 && panel.group === g) break;
      panel_operator_inst.tap(1'h0);
    end
  endtask : goGroup

  task automatic complete_run();
    $display("checks %0d errors %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    tick(20000);
    errors++;
    complete_run();
  end

  initial begin
    rst_n = 1'h0;
    errActive = 4'h0;
    newError = 1'h0;
    reportViewed = 1'h0;
    addrAttached = 1'h0;
    addrPos = 5'h00;
    errors = 0;
    numChecks = 0;
    toggles = 0;
    lastSet = 1'h0;
    tick(3);
    rst_n <= 1'h1;
    tick(1);
    `CHECK({panel.showNumber, panel.lowerLed, panel.upperLed, panel.horn}, 4'h8)
    tick(6);
    `CHECK({panel.commEnable, panel.number}, 6'h00)
    // Attached positions, then detached again
    foreach (posList[i]) begin
      addrAttached <= 1'h1;
      addrPos <= posList[i];
      tick(6);
      `CHECK({panel.commEnable, panel.number}, {1'h1, posList[i]})
    end
    addrAttached <= 1'h0;
    tick(6);
    `CHECK({panel.commEnable, panel.number}, 6'h00)
    // Group stepping and idle return
    for (int i = 0; i < 6; i++) begin
      panel_operator_inst.tap(1'h0);
      `CHECK({panel.showNumber, panel.group, panel.flash}, {1'h0, grpSeq[i], 1'h0})
    end
    tick(60);
    `CHECK(panel.showNumber, 1'h0)
    tick(60);
    `CHECK(panel.showNumber, 1'h1)
    panel_operator_inst.tap(1'h0);
    panel_operator_inst.tap(1'h1);
    `CHECK(panel.showNumber, 1'h1)
    // Error report and horn patterns
    raise(4'h4);
    tick(1);
    `CHECK({panel.upperLed, panel.flash, panel.faultForward}, 3'h7)
    `CHECK({panel.showNumber, panel.group}, {1'h0, enclosure_alarm_pkg::GV_FAULT})
    foreach (sevList[i]) begin
      errActive <= sevList[i];
      tick(40);
      hornHighs(h);
      `CHECK(h, beeps[i] * SLOTS)
    end
    // Pending reports
    raise(4'h1);
    view();
    tick(2);
    `CHECK(panel.upperLed, 1'h1)
    view();
    tick(2);
    `CHECK(panel.upperLed, 1'h0)
    // Mute, new error, unmute
    panel_operator_inst.holdUntil(1'h0, 1'h1, seen);
    `CHECK({seen, panel.lowerLed}, 2'h3)
    hornHighs(h);
    `CHECK(h, 0)
    raise(4'h4);
    tick(1);
    `CHECK(panel.lowerLed, 1'h0)
    tick(4);
    hornHighs(h);
    `CHECK(h, 3 * SLOTS)
    panel_operator_inst.holdUntil(1'h0, 1'h1, seen);
    panel_operator_inst.holdUntil(1'h0, 1'h0, seen);
    `CHECK({seen, panel.lowerLed}, 2'h2)
    hornHighs(h);
    `CHECK(h, 3 * SLOTS)
    errActive <= 4'h0;
    tick(6);
    hornHighs(h);
    `CHECK({h[5:0], panel.faultForward}, 7'h00)
    // Disable through the setting editor
    goGroup(enclosure_alarm_pkg::GV_ALARM_SETTING);
    panel_operator_inst.holdUntil(1'h1, 1'h1, seen);
    `CHECK({seen, panel.flash, panel.settingOn}, 3'h7)
    panel_operator_inst.tap(1'h1);
    `CHECK(panel.settingOn, 1'h0)
    toggles = 0;
    panel_operator_inst.holdFor(1'h1, 70);
    `CHECK(toggles >= 2, 1'h1)
    if (panel.settingOn === 1'h1) panel_operator_inst.tap(1'h1);
    panel_operator_inst.tap(1'h0);
    `CHECK({panel.showSetting, panel.flash, panel.lowerLed}, 3'h1)
    `CHECK(panel.group, enclosure_alarm_pkg::GV_ALARM_SETTING)
    raise(4'h4);
    tick(4);
    hornHighs(h);
    `CHECK(h, 0)
    `CHECK({panel.lowerLed, panel.upperLed, panel.faultForward}, 3'h7)
    `CHECK(panel.group, enclosure_alarm_pkg::GV_FAULT)
    // Enable again
    goGroup(enclosure_alarm_pkg::GV_ALARM_SETTING);
    panel_operator_inst.holdUntil(1'h1, 1'h1, seen);
    `CHECK({seen, panel.settingOn}, 2'h2)
    panel_operator_inst.tap(1'h1);
    `CHECK(panel.settingOn, 1'h1)
    panel_operator_inst.tap(1'h0);
    `CHECK({panel.showSetting, panel.lowerLed}, 2'h0)
    hornHighs(h);
    `CHECK(h, 3 * SLOTS)
    complete_run();
  end

endmodule : enclosure_alarm_panel_tb

//--- test/panel_operator.sv
module panel_operator (
  input  wire logic                       ref_clk,
  input  enclosure_alarm_pkg::panel_out_t panel,
  output logic                            upperBtn_n,
  output logic                            lowerBtn_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // Released buttons sit at the pull-up level
  initial begin
    upperBtn_n = 1'h1;
    lowerBtn_n = 1'h1;
  end

  // One pin change just after an edge
  task automatic drive(input logic upper, input logic lvl);
    @(posedge ref_clk);
    if (upper) begin
      upperBtn_n <= lvl;
    end else begin
      lowerBtn_n <= lvl;
    end
  endtask : drive

  // Press and release, with a contact bounce first
  task automatic tap(input logic upper);
    drive(upper, 1'h0);
    drive(upper, 1'h1);
    drive(upper, 1'h0);
    repeat (12) @(posedge ref_clk);
    drive(upper, 1'h1);
    repeat (14) @(posedge ref_clk);
  endtask : tap

  // Hold until the lower LED or showSetting shows the wanted level
  task automatic holdUntil(input logic upper, input logic want, output logic seen);
    drive(upper, 1'h0);
    seen = 1'h0;
    for (int i = 0; i < 80 && !seen; i++) begin
      @(posedge ref_clk);
      seen = upper ? (panel.showSetting === want) : (panel.lowerLed === want);
    end
    drive(upper, 1'h1);
    repeat (14) @(posedge ref_clk);
  endtask : holdUntil

  // Hold for a fixed time, then release
  task automatic holdFor(input logic upper, input int cycles);
    drive(upper, 1'h0);
    repeat (cycles) @(posedge ref_clk);
    drive(upper, 1'h1);
    repeat (14) @(posedge ref_clk);
  endtask : holdFor

endmodule : panel_operator
